// *** servo_io_signal_router.v ***
// Servo I/O connector signal router with APB register access
// What this block does
// - Five input pins, codes in two map registers
// - Each input circuit feeds only the one function its code names
// - Repeated function taken from highest pin only
// - Standard input code table, codes zero to nine
// - 400V table reorders codes one to three
// - Three output pairs, one field each
// - Pair drives OR of its mapped functions
// - Output code table zero to eight, a, b
// - Parameters change mapping and polarity
// - Rewriting a field retargets its pair
// - Field zero first pair, code four brake
// - Brake unassigned by default
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "io_router_defines.vh"

module servo_io_signal_router #(
  parameter IN_PINS = 5,
  parameter OUT_PAIRS = 3
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [IN_PINS-1:0] io_in_pins,
  output reg [OUT_PAIRS-1:0] io_out_pairs,
  output reg servo_on_in,
  output reg fwd_travel_inhibit,
  output reg rev_travel_inhibit,
  output reg fwd_ext_torque_cap,
  output reg rev_ext_torque_cap,
  output reg gain_switch_in,
  output reg homing_in,
  output reg remote_io_in,
  output reg probe_latch_in_1,
  output reg probe_latch_in_2,
  output reg alt_code1_in,
  input wire in_position_out,
  input wire rotation_detect_out,
  input wire servo_ready_out,
  input wire torque_limited_out,
  input wire brake_out,
  input wire index_pulse_out,
  input wire overtravel_out,
  input wire motor_energized_out,
  input wire torque_detect_out
);

  // ****************************************
  // Registers
  // ****************************************
  reg [31:0] in_map_a_q;
  reg [31:0] in_map_b_q;
  reg [31:0] out_map_q;
  reg [31:0] ctrl_q;
  reg [1:0] host_out_q;
  reg [IN_PINS-1:0] pin_q;

  wire hv_mode = ctrl_q[`CTRL_HV_BIT];
  wire [IN_PINS-1:0] in_pol = ctrl_q[`CTRL_IPOL_LSB +: IN_PINS];
  wire [OUT_PAIRS-1:0] out_pol = ctrl_q[`CTRL_OPOL_LSB +: OUT_PAIRS];

  // Access phase decode; slave always answers with no wait states
  wire access = psel & penable;
  wire wr_en = access & pwrite;
  wire addr_ok = (paddr == `ADDR_IN_MAP_A) || (paddr == `ADDR_IN_MAP_B) || (paddr == `ADDR_OUT_MAP) ||
                 (paddr == `ADDR_CTRL) || (paddr == `ADDR_IN_STATUS) || (paddr == `ADDR_OUT_STATUS) ||
                 (paddr == `ADDR_FUNC_STATUS) || (paddr == `ADDR_HOST_OUT);

  // ****************************************
  // Register writes
  // ****************************************
  // Map and polarity words are software-configurable at any time
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_map_a_q <= `RST_IN_MAP_A;
      in_map_b_q <= `RST_IN_MAP_B;
      out_map_q <= `RST_OUT_MAP; // No field holds the brake code
      ctrl_q <= `RST_CTRL;
      host_out_q <= 2'h0;
    end else if (wr_en) begin
      case (paddr)
        `ADDR_IN_MAP_A: in_map_a_q <= {16'h0000, pwdata[15:0]};
        `ADDR_IN_MAP_B: in_map_b_q <= {28'h0000000, pwdata[3:0]};
        `ADDR_OUT_MAP: out_map_q <= {20'h00000, pwdata[11:0]};
        `ADDR_CTRL: ctrl_q <= {13'h0000, pwdata[18:16], 3'h0, pwdata[12:8], 7'h00, pwdata[0]};
        `ADDR_HOST_OUT: host_out_q <= pwdata[1:0];
        default: host_out_q <= host_out_q;
      endcase
    end
  end

  // ****************************************
  // Input side
  // ****************************************
  // Pin levels registered once after polarity, so every function sees the same sample
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pin_q <= {IN_PINS{1'b0}};
    else
      pin_q <= io_in_pins ^ in_pol;
  end

  wire [IN_PINS*4-1:0] pin_codes = {in_map_b_q[3:0], in_map_a_q[15:0]};
  wire [`FUNC_NUM-1:0] code_hit; // Function levels by code

  // One selector per code; only the highest mapped pin drives each function
  genvar g;
  generate
    for (g = 0; g < `FUNC_NUM; g = g + 1) begin : g_in
      in_func_select #(
        .PINS(IN_PINS),
        .FUNC_CODE(g[3:0])
      ) u_sel (
        .pin_codes(pin_codes),
        .pin_level(pin_q),
        .func_level(code_hit[g])
      );
    end
  endgenerate

  // Table choice moves codes 1 to 3 only; 4 to 9 are common
  reg [`FUNC_NUM-1:0] func_d;
  reg alt_d;
  always @* begin
    func_d = code_hit;
    alt_d = 1'b0;
    if (hv_mode) begin
      alt_d = code_hit[`IC_HV_ALT];
      func_d[`FB_FWD_INHIBIT] = code_hit[`IC_HV_FWD_INHIBIT];
      func_d[`FB_REV_INHIBIT] = code_hit[`IC_HV_REV_INHIBIT];
      func_d[`FB_FWD_CAP] = 1'b0; // No code on this table
      func_d[`FB_REV_CAP] = code_hit[`IC_HV_REV_CAP];
    end
  end

  // Function outputs straight from flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      servo_on_in <= 1'b0;
      fwd_travel_inhibit <= 1'b0;
      rev_travel_inhibit <= 1'b0;
      fwd_ext_torque_cap <= 1'b0;
      rev_ext_torque_cap <= 1'b0;
      gain_switch_in <= 1'b0;
      homing_in <= 1'b0;
      remote_io_in <= 1'b0;
      probe_latch_in_1 <= 1'b0;
      probe_latch_in_2 <= 1'b0;
      alt_code1_in <= 1'b0;
    end else begin
      servo_on_in <= func_d[`FB_SERVO_ON];
      fwd_travel_inhibit <= func_d[`FB_FWD_INHIBIT];
      rev_travel_inhibit <= func_d[`FB_REV_INHIBIT];
      fwd_ext_torque_cap <= func_d[`FB_FWD_CAP];
      rev_ext_torque_cap <= func_d[`FB_REV_CAP];
      gain_switch_in <= func_d[`FB_GAIN];
      homing_in <= func_d[`FB_HOMING];
      remote_io_in <= func_d[`FB_REMOTE];
      probe_latch_in_1 <= func_d[`FB_PROBE1];
      probe_latch_in_2 <= func_d[`FB_PROBE2];
      alt_code1_in <= alt_d;
    end
  end

  // ****************************************
  // Output side
  // ****************************************
  // Function vector indexed by output code; slot 9 has no function
  wire [`OUT_FUNCS-1:0] out_funcs = {host_out_q[1], host_out_q[0], 1'b0, torque_detect_out,
                                    motor_energized_out, overtravel_out, index_pulse_out, brake_out,
                                    torque_limited_out, servo_ready_out, rotation_detect_out,
                                    in_position_out};
  wire [OUT_PAIRS-1:0] pair_d;

  // Field k drives pair k; field 0 is the first pair
  generate
    for (g = 0; g < OUT_PAIRS; g = g + 1) begin : g_out
      out_pair_mux #(
        .NFUNC(`OUT_FUNCS)
      ) u_mux (
        .code(out_map_q[g*4 +: 4]),
        .func_vec(out_funcs),
        .pair_level(pair_d[g])
      );
    end
  endgenerate

  // Registered pairs; each pair owns one field, so the OR of its mapped
  // functions is the single function that field selects
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      io_out_pairs <= {OUT_PAIRS{1'b0}};
    else
      io_out_pairs <= pair_d ^ out_pol;
  end

  // ****************************************
  // APB read path
  // ****************************************
  reg [31:0] rd_d;
  always @* begin
    case (paddr)
      `ADDR_IN_MAP_A: rd_d = in_map_a_q;
      `ADDR_IN_MAP_B: rd_d = in_map_b_q;
      `ADDR_OUT_MAP: rd_d = out_map_q;
      `ADDR_CTRL: rd_d = ctrl_q;
      `ADDR_IN_STATUS: rd_d = {27'h0000000, pin_q};
      `ADDR_OUT_STATUS: rd_d = {29'h00000000, io_out_pairs};
      `ADDR_FUNC_STATUS: rd_d = {21'h000000, alt_code1_in, probe_latch_in_2, probe_latch_in_1,
                                 remote_io_in, homing_in, gain_switch_in, rev_ext_torque_cap,
                                 fwd_ext_torque_cap, rev_travel_inhibit, fwd_travel_inhibit,
                                 servo_on_in};
      `ADDR_HOST_OUT: rd_d = {30'h00000000, host_out_q};
      default: rd_d = 32'h00000000;
    endcase
  end

  // Answer in the setup-to-access transition: pready high one cycle after setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      prdata <= (psel & ~penable & ~pwrite) ? rd_d : 32'h00000000;
    end
  end

endmodule // servo_io_signal_router

// *** io_router_defines.vh ***
// Constants for the I/O signal router: register map, field layout, codes and reset values
`ifndef IO_ROUTER_DEFINES_VH
`define IO_ROUTER_DEFINES_VH

// ****************************************
// Register byte addresses
// ****************************************
`define ADDR_IN_MAP_A 12'h000
`define ADDR_IN_MAP_B 12'h004
`define ADDR_OUT_MAP 12'h008
`define ADDR_CTRL 12'h00c
`define ADDR_IN_STATUS 12'h010
`define ADDR_OUT_STATUS 12'h014
`define ADDR_FUNC_STATUS 12'h018
`define ADDR_HOST_OUT 12'h01c

// ****************************************
// Field layout: 4-bit code fields
// ****************************************
`define FIELD_W 4
`define MAP_A_FIELDS 4
`define OUT_FIELDS 3
`define IN_PINS 5
`define FUNC_NUM 10
`define OUT_FUNCS 12

// ****************************************
// Reset values (brake not allocated; code f = unused)
// ****************************************
`define RST_IN_MAP_A 32'h0000_3210
`define RST_IN_MAP_B 32'h0000_0004
`define RST_OUT_MAP 32'h0000_0210
`define RST_CTRL 32'h0000_0000

// ****************************************
// Control register bits
// ****************************************
`define CTRL_HV_BIT 0
`define CTRL_IPOL_LSB 8
`define CTRL_OPOL_LSB 16

// ****************************************
// Input function codes, standard table
// ****************************************
`define IC_SERVO_ON 4'h0
`define IC_FWD_INHIBIT 4'h1
`define IC_REV_INHIBIT 4'h2
`define IC_FWD_CAP 4'h3
`define IC_REV_CAP 4'h4
`define IC_LAST 4'h9

// Input function codes, 400 V table
`define IC_HV_ALT 4'h1
`define IC_HV_FWD_INHIBIT 4'h2
`define IC_HV_REV_INHIBIT 4'h3
`define IC_HV_REV_CAP 4'h4

// Function vector bit positions
`define FB_SERVO_ON 0
`define FB_FWD_INHIBIT 1
`define FB_REV_INHIBIT 2
`define FB_FWD_CAP 3
`define FB_REV_CAP 4
`define FB_GAIN 5
`define FB_HOMING 6
`define FB_REMOTE 7
`define FB_PROBE1 8
`define FB_PROBE2 9

// Output function codes
`define OC_BRAKE 4'h4
`define OC_HOST0 4'ha
`define OC_HOST1 4'hb

`endif

// *** in_func_select.v ***
// Input function selector: one function taken from the highest-priority pin mapped to it
`timescale 1ns/1ps
`include "io_router_defines.vh"

module in_func_select #(
  parameter PINS = 5,
  parameter [3:0] FUNC_CODE = 4'h0
) (
  input wire [PINS*4-1:0] pin_codes,
  input wire [PINS-1:0] pin_level,
  output reg func_level
);

  integer i;
  reg found;

  // ****************************************
  // Priority scan
  // ****************************************
  // Highest pin number wins; later circuits are ignored for this function
  always @* begin
    found = 1'b0;
    func_level = 1'b0; // Unmapped function reads inactive
    for (i = PINS - 1; i >= 0; i = i - 1) begin
      if (!found && pin_codes[i*4 +: 4] == FUNC_CODE) begin
        found = 1'b1;
        func_level = pin_level[i];
      end
    end
  end

endmodule // in_func_select

// *** out_pair_mux.v ***
// Output pair driver: passes the one function that the pair's code field selects
`timescale 1ns/1ps
`include "io_router_defines.vh"

module out_pair_mux #(
  parameter NFUNC = 12
) (
  input wire [3:0] code,
  input wire [NFUNC-1:0] func_vec,
  output reg pair_level
);

  // ****************************************
  // Code decode
  // ****************************************
  // Code 9 and codes above b are undefined and give an inactive pair
  always @* begin
    if (code < NFUNC)
      pair_level = func_vec[code]; // Rewriting the code retargets the pair
    else
      pair_level = 1'b0;
  end

endmodule // out_pair_mux

// *** host_wiring_model.sv ***
// Host controller wiring model: drives the router's input pins
`timescale 1ns/1ps
module host_wiring_model (
  input wire logic pclk,
  input wire logic [4:0] pin_req,
  output logic [4:0] pin_drv = 5'h00
);
  // Pins follow the host one clock late, like a real output stage
  always @(posedge pclk) begin
    pin_drv <= pin_req;
  end
endmodule // host_wiring_model

// *** servo_io_router_assertions.sv ***
// Register port checker for the servo I/O signal router
`timescale 1ns/1ps
module servo_io_router_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Zero wait states: software relies on a fixed two-cycle access
  ready_after_setup_a: assert property (psel && !penable |=> pready) else $error("no ready");
  ready_single_a: assert property (pready |=> !pready) else $error("ready stuck");
  ready_cause_a: assert property (pready |-> $past(psel && !penable)) else $error("stray ready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("idle data");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("lone error");
  err_unmapped_a: assert property (psel && !penable && paddr > 12'h01c |=> pslverr) else $error("no error");
  ok_mapped_a: assert property (psel && !penable && paddr <= 12'h01c && paddr[1:0] == 2'b00 |=> !pslverr)
    else $error("false error");
  mapb_reserved_a: assert property (psel && !penable && !pwrite && paddr == 12'h004 |=> prdata[31:4] == 28'h0)
    else $error("reserved bits");
endmodule // servo_io_router_checker

bind servo_io_signal_router servo_io_router_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// *** servo_io_signal_router_tb_top.sv ***
// Self-checking bench for the servo I/O signal router
`timescale 1ns/1ps
module servo_io_signal_router_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [4:0] pin_req = 5'h00;
  logic [4:0] pins;
  logic [2:0] pairs;
  logic [8:0] fin = 9'h000;
  logic [10:0] fv;
  logic [31:0] rd;
  logic er;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  // ****************************************
  // Design, host wiring and clock
  // ****************************************
  servo_io_signal_router i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .io_in_pins(pins),
    .io_out_pairs(pairs), .servo_on_in(fv[0]), .fwd_travel_inhibit(fv[1]), .rev_travel_inhibit(fv[2]),
    .fwd_ext_torque_cap(fv[3]), .rev_ext_torque_cap(fv[4]), .gain_switch_in(fv[5]), .homing_in(fv[6]),
    .remote_io_in(fv[7]), .probe_latch_in_1(fv[8]), .probe_latch_in_2(fv[9]), .alt_code1_in(fv[10]),
    .in_position_out(fin[0]), .rotation_detect_out(fin[1]), .servo_ready_out(fin[2]), .torque_limited_out(fin[3]),
    .brake_out(fin[4]), .index_pulse_out(fin[5]), .overtravel_out(fin[6]), .motor_energized_out(fin[7]),
    .torque_detect_out(fin[8]));
  host_wiring_model i_host (.pclk(pclk), .pin_req(pin_req), .pin_drv(pins));
  // Free-running clock and a hang guard
  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      $display("Error at %0t: timeout", $time);
      results();
    end
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Wait for the answer rather than assume the latency; only the hang guard ends a wait
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // Pin path takes a host edge plus two router edges
  task settle;
    repeat (4) @(posedge pclk);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_regs;
    rchk(12'h000, 32'h3210);
    rchk(12'h004, 32'h4);
    rchk(12'h008, 32'h210);
    rchk(12'h00c, 32'h0);
    rchk(12'h020, 32'h0);
    chk(32'(er), 32'h1);
    apb(1'b1, 12'h004, 32'hffffffff);
    rchk(12'h004, 32'hf);
  endtask
  task t_codes;
    int hv[5] = '{0, 10, 1, 2, 4};
    pin_req <= 5'h01;
    for (int c = 0; c < 10; c++) begin
      apb(1'b1, 12'h000, 32'hfff0 | c);
      settle();
      chk(32'(fv), 32'h1 << c);
    end
    apb(1'b1, 12'h00c, 32'h1);
    for (int c = 0; c < 5; c++) begin
      apb(1'b1, 12'h000, 32'hfff0 | c);
      settle();
      chk(32'(fv), 32'h1 << hv[c]);
    end
    apb(1'b1, 12'h00c, 32'h0);
  endtask
  // Pin 4 outranks pin 0 for a shared function
  task t_prio;
    apb(1'b1, 12'h000, 32'hfff5);
    apb(1'b1, 12'h004, 32'h5);
    settle();
    chk(32'(fv), 32'h0);
    pin_req <= 5'h11;
    settle();
    chk(32'(fv), 32'h20);
  endtask
  // Every code with all others active and its function low, then with its function alone
  task t_out;
    logic [10:0] x;
    int idx;
    for (int c = 0; c < 16; c++) begin
      idx = (c < 9) ? c : (c == 10) ? 9 : (c == 11) ? 10 : 11;
      apb(1'b1, 12'h008, 32'hff0 | c);
      for (int p = 0; p < 2; p++) begin
        x = 11'h1 << idx;
        x = p ? x : ~x;
        fin <= x[8:0];
        apb(1'b1, 12'h01c, 32'(x[10:9]));
        settle();
        chk(32'(pairs), 32'(p == 1 && idx < 11));
      end
    end
  endtask
  task t_retarget;
    apb(1'b1, 12'h01c, 32'h0);
    apb(1'b1, 12'h008, 32'h210);
    fin <= 9'h010;
    settle();
    chk(32'(pairs), 32'h0);
    apb(1'b1, 12'h008, 32'hf4f);
    settle();
    chk(32'(pairs), 32'h2);
    fin <= 9'h002;
    apb(1'b1, 12'h008, 32'h110);
    settle();
    chk(32'(pairs), 32'h6);
  endtask
  task t_pol;
    fin <= 9'h000;
    pin_req <= 5'h00;
    apb(1'b1, 12'h000, 32'h3210);
    apb(1'b1, 12'h004, 32'h4);
    apb(1'b1, 12'h008, 32'h210);
    apb(1'b1, 12'h00c, 32'h10100);
    settle();
    chk(32'(fv), 32'h1);
    chk(32'(pairs), 32'h1);
    rchk(12'h010, 32'h1);
    rchk(12'h014, 32'h1);
    rchk(12'h018, 32'h1);
  endtask
  // Reset in mid-run restores the default allocation and polarity
  task t_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk(32'(pairs), 32'h0);
    rchk(12'h008, 32'h210);
    rchk(12'h00c, 32'h0);
    rchk(12'h000, 32'h3210);
  endtask
  task results;
    if (bad_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_codes();
    t_prio();
    t_out();
    t_retarget();
    t_pol();
    t_reset();
    results();
  end
endmodule // servo_io_signal_router_tb_top
